/* File: hdl/urb_uart.v */
// uart with rate setting, reset tristate and bypass routing, axi4-lite registers
`timescale 1ns/1ps
`include "urb_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - bit rate equals setting divided by 0.004096
// - 0x0027=9600, 0x01d8=115200, 0x2c3d=2764800 bps
// - serial outputs high impedance during reset
// - after reset host bus reaches internal uart
// - bypass command routes host lines to pins
// - bypass then deep sleep, routing kept
// - only reset leaves bypass
// - rts/cts active low, flow control optional
// - 8 data bits, parity none/odd/even, 1-2 stops
module urb_uart #(
  parameter CLK_HZ = 200000000
) (
  // clock and reset
  input wire clock,
  input wire nrst,
  // axi4-lite write address/data/response
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // host serial bus
  input wire host_rx,
  output wire host_tx_o,
  output wire host_tx_oe,
  input wire host_cts_n,
  output wire host_rts_n_o,
  output wire host_rts_n_oe,
  // bypass pin group: [4] tx out, [5] rx in, [6] rts out, [7] cts in
  input wire [7:4] bypass_pin_group_i,
  output wire [7:4] bypass_pin_group_o,
  output wire [7:4] bypass_pin_group_oe,
  // core state
  output wire deep_sleep
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [15:0] baud_q;
  reg [3:0] ctrl_q;
  reg bypass_q;
  reg par_err_q, frm_err_q, rx_valid_q;
  reg [7:0] rx_data_q;
  reg drive_q;
  wire tick16;
  wire tx_busy;
  reg tx_start;
  reg [7:0] tx_byte;
  reg rx_pop;
  // nothing drives until reset has released, then the internal port owns the bus
  always @(posedge clock or negedge nrst) begin
    if (!nrst) drive_q <= 1'b0;
    else drive_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin routing
  wire core_tx, core_rts_n;
  wire rx_in = bypass_q ? 1'b1 : host_rx;
  wire cts_n_in = bypass_q ? 1'b0 : host_cts_n;
  // bypass is wires only so it still works while the core clock sleeps
  assign host_tx_o = bypass_q ? bypass_pin_group_i[5] : core_tx;
  assign host_rts_n_o = bypass_q ? bypass_pin_group_i[7] : core_rts_n;
  assign host_tx_oe = drive_q;
  assign host_rts_n_oe = drive_q;
  assign bypass_pin_group_o = {1'b0, host_cts_n, 1'b0, host_rx};
  assign bypass_pin_group_oe = {1'b0, bypass_q, 1'b0, bypass_q};
  assign deep_sleep = bypass_q;
  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write
  reg aw_q, w_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  wire wr_go = aw_q && w_q && !s_axi_bvalid;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `URB_RESP_OKAY;
      baud_q <= `URB_BAUD_RST;
      ctrl_q <= `URB_CTRL_RST;
      bypass_q <= 1'b0;
      tx_start <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      tx_start <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `URB_RESP_OKAY;
        case (awaddr_q)
          `URB_OFS_BAUD: begin
            if (wstrb_q[0]) baud_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) baud_q[15:8] <= wdata_q[15:8];
          end
          `URB_OFS_CTRL: if (wstrb_q[0]) ctrl_q <= wdata_q[3:0];
          // latched until reset: nothing else clears it
          `URB_OFS_CMD: if (wdata_q == `URB_CMD_BYPASS && wstrb_q == 4'hf) bypass_q <= 1'b1;
          `URB_OFS_TXD: begin
            if (wstrb_q[0] && !tx_busy && !bypass_q) begin
              tx_start <= 1'b1;
              tx_byte <= wdata_q[7:0];
            end
          end
          `URB_OFS_STAT: ;
          `URB_OFS_RXD: ;
          default: s_axi_bresp <= `URB_RESP_SLVERR;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read
  assign s_axi_arready = !s_axi_rvalid;
  wire [31:0] stat_w = {26'h0, bypass_q, bypass_q, frm_err_q, par_err_q, rx_valid_q, tx_busy};
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `URB_RESP_OKAY;
      rx_pop <= 1'b0;
    end else begin
      rx_pop <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `URB_RESP_OKAY;
        case (s_axi_araddr)
          `URB_OFS_BAUD: s_axi_rdata <= {16'h0000, baud_q};
          `URB_OFS_CTRL: s_axi_rdata <= {28'h0, ctrl_q};
          `URB_OFS_STAT: s_axi_rdata <= stat_w;
          `URB_OFS_CMD: s_axi_rdata <= 32'h0000_0000;
          `URB_OFS_TXD: s_axi_rdata <= 32'h0000_0000;
          `URB_OFS_RXD: begin
            s_axi_rdata <= {24'h0, rx_data_q};
            rx_pop <= 1'b1;
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `URB_RESP_SLVERR;
          end
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // bit-rate generator; setting is read live so a write takes effect at once
  urb_tick_gen #(.CLK_HZ(CLK_HZ)) u_tick (
    .clock(clock),
    .nrst(nrst),
    .baud_divisor_setting(baud_q),
    .tick16(tick16)
  );
  ////////////////////////////////////////////////////////////////////////////
  // transmitter: start, 8 data lsb first, optional parity, 1 or 2 stops
  localparam [4:0] TX_IDLE = 5'b00001, TX_WAIT = 5'b00010, TX_START = 5'b00100, TX_DATA = 5'b01000,
    TX_STOP = 5'b10000;
  reg [4:0] tx_st_q;
  reg [10:0] tx_sh_q;
  reg [3:0] tx_cnt_q, tx_sub_q;
  reg tx_line_q;
  wire [3:0] tx_nbits = 4'd8 + {3'd0, ctrl_q[`URB_CTRL_PAR_EN]};
  wire tx_par = ^tx_byte ^ ctrl_q[`URB_CTRL_PAR_ODD];
  assign tx_busy = !tx_st_q[0];
  assign core_tx = tx_line_q;
  assign core_rts_n = !(ctrl_q[`URB_CTRL_FLOW] && !rx_valid_q);
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 11'h000;
      tx_cnt_q <= 4'h0;
      tx_sub_q <= 4'h0;
      tx_line_q <= 1'b1;
    end else begin
      case (tx_st_q)
        TX_IDLE: if (tx_start) begin
          tx_sh_q <= {2'b11, tx_par, tx_byte};
          tx_st_q <= TX_WAIT;
        end
        // with flow control on, cts held high (inactive) stalls the next character
        TX_WAIT: if (tick16 && !(ctrl_q[`URB_CTRL_FLOW] && cts_n_in)) begin
          tx_line_q <= 1'b0;
          tx_sub_q <= 4'h0;
          tx_st_q <= TX_START;
        end
        TX_START: if (tick16) begin
          tx_sub_q <= tx_sub_q + 4'd1;
          if (tx_sub_q == 4'hf) begin
            tx_line_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_cnt_q <= 4'd1;
            tx_st_q <= TX_DATA;
          end
        end
        TX_DATA: if (tick16) begin
          tx_sub_q <= tx_sub_q + 4'd1;
          if (tx_sub_q == 4'hf) begin
            if (tx_cnt_q == tx_nbits) begin
              tx_line_q <= 1'b1;
              tx_cnt_q <= 4'd0;
              tx_st_q <= TX_STOP;
            end else begin
              tx_line_q <= tx_sh_q[0];
              tx_sh_q <= {1'b1, tx_sh_q[10:1]};
              tx_cnt_q <= tx_cnt_q + 4'd1;
            end
          end
        end
        TX_STOP: if (tick16) begin
          tx_sub_q <= tx_sub_q + 4'd1;
          if (tx_sub_q == 4'hf) begin
            tx_cnt_q <= tx_cnt_q + 4'd1;
            if (tx_cnt_q == {3'd0, ctrl_q[`URB_CTRL_STOP2]}) tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // receiver: mid-bit sampling at 16x, one character holding register
  localparam [2:0] RX_IDLE = 3'b001, RX_BITS = 3'b010, RX_STOP = 3'b100;
  reg [2:0] rx_st_q;
  reg [3:0] rx_sub_q, rx_cnt_q;
  reg [8:0] rx_sh_q;
  wire [3:0] rx_nbits = 4'd8 + {3'd0, ctrl_q[`URB_CTRL_PAR_EN]};
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_st_q <= RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      par_err_q <= 1'b0;
      frm_err_q <= 1'b0;
    end else begin
      if (rx_pop) begin
        rx_valid_q <= 1'b0;
        par_err_q <= 1'b0;
        frm_err_q <= 1'b0;
      end
      if (tick16) begin
        case (rx_st_q)
          RX_IDLE: begin
            rx_sub_q <= 4'h0;
            rx_cnt_q <= 4'h0;
            if (!rx_in) rx_st_q <= RX_BITS;
          end
          RX_BITS: begin
            rx_sub_q <= rx_sub_q + 4'd1;
            if (rx_sub_q == 4'h7 && rx_cnt_q == 4'h0 && rx_in) rx_st_q <= RX_IDLE;
            else if (rx_sub_q == 4'h7) begin
              if (rx_cnt_q != 4'h0) rx_sh_q <= {rx_in, rx_sh_q[8:1]};
              if (rx_cnt_q == rx_nbits) rx_st_q <= RX_STOP;
              rx_cnt_q <= rx_cnt_q + 4'd1;
            end
          end
          RX_STOP: begin
            rx_sub_q <= rx_sub_q + 4'd1;
            if (rx_sub_q == 4'h7) begin
              // set wins over a same-cycle pop
              rx_valid_q <= 1'b1;
              rx_data_q <= ctrl_q[`URB_CTRL_PAR_EN] ? rx_sh_q[7:0] : rx_sh_q[8:1];
              if (ctrl_q[`URB_CTRL_PAR_EN] && (^rx_sh_q ^ ctrl_q[`URB_CTRL_PAR_ODD])) par_err_q <= 1'b1;
              if (!rx_in) frm_err_q <= 1'b1;
              rx_st_q <= RX_IDLE;
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end
endmodule // urb_uart

/* File: hdl/urb_consts.vh */
// constants for the uart rate and bypass routing block
`ifndef URB_CONSTS_VH
`define URB_CONSTS_VH
// register byte offsets on the axi4-lite slave
`define URB_OFS_BAUD 8'h00
`define URB_OFS_CTRL 8'h04
`define URB_OFS_STAT 8'h08
`define URB_OFS_CMD 8'h0c
`define URB_OFS_TXD 8'h10
`define URB_OFS_RXD 8'h14
// control fields
`define URB_CTRL_PAR_EN 0
`define URB_CTRL_PAR_ODD 1
`define URB_CTRL_STOP2 2
`define URB_CTRL_FLOW 3
// status fields
`define URB_STAT_TX_BUSY 0
`define URB_STAT_RX_VALID 1
`define URB_STAT_PAR_ERR 2
`define URB_STAT_FRM_ERR 3
`define URB_STAT_BYPASS 4
`define URB_STAT_SLEEP 5
// reset values
`define URB_BAUD_RST 16'h01d8
`define URB_CTRL_RST 4'h0
// bypass command code written to the command register
`define URB_CMD_BYPASS 32'h0000_00b1
// rate = setting / 0.004096 = setting * 1e6 / 4096; accumulator phase width
`define URB_PHASE_W 32
// axi responses
`define URB_RESP_OKAY 2'b00
`define URB_RESP_SLVERR 2'b10
`endif

/* File: hdl/urb_tick_gen.v */
// fractional bit-rate tick generator, 16x oversampling enable
`timescale 1ns/1ps
`include "urb_consts.vh"
module urb_tick_gen #(
  parameter CLK_HZ = 200000000
) (
  // clock and reset
  input wire clock,
  input wire nrst,
  // setting
  input wire [15:0] baud_divisor_setting,
  // one-cycle enable at 16x the bit rate
  output reg tick16
);
  // tick16 rate = 16 * setting * 1e6 / 4096 = setting * 15625 / 4
  localparam [31:0] STEP_NUM = 32'd15625;
  localparam [31:0] PHASE_MOD = CLK_HZ * 4;
  wire [31:0] step;
  reg [31:0] acc_q;
  wire [32:0] sum;
  assign step = baud_divisor_setting * STEP_NUM;
  assign sum = {1'b0, acc_q} + {1'b0, step};
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc_q <= 32'h0000_0000;
      tick16 <= 1'b0;
    end else if (sum >= {1'b0, PHASE_MOD}) begin
      acc_q <= sum[31:0] - PHASE_MOD;
      tick16 <= 1'b1;
    end else begin
      acc_q <= sum[31:0];
      tick16 <= 1'b0;
    end
  end
endmodule // urb_tick_gen

/* File: verif/urb_chk_properties.sv */
// assertion checker for the uart rate and bypass block
`timescale 1ns/1ps
module urb_chk (
  // clock and reset
  input wire clock,
  input wire nrst,
  // register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // serial lines and pins
  input wire host_rx,
  input wire host_cts_n,
  input wire host_tx_o,
  input wire host_tx_oe,
  input wire host_rts_n_o,
  input wire host_rts_n_oe,
  input wire [7:4] bypass_pin_group_i,
  input wire [7:4] bypass_pin_group_o,
  input wire [7:4] bypass_pin_group_oe,
  input wire deep_sleep
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // reset itself is the antecedent here, so no disable
  chk_pins_float: assert property (disable iff (1'b0)
    !nrst |-> {host_tx_oe, host_rts_n_oe, bypass_pin_group_oe} == 6'h0) else $error("pins driven in reset");
  chk_tx_drive: assert property (!deep_sleep && $past(nrst) |-> host_tx_oe)
    else $error("tx not driven");
  chk_route_in: assert property (deep_sleep |-> bypass_pin_group_o[4] == host_rx &&
    bypass_pin_group_o[6] == host_cts_n) else $error("host lines not passed to pins");
  chk_route_out: assert property (deep_sleep |-> host_tx_o == bypass_pin_group_i[5] &&
    host_rts_n_o == bypass_pin_group_i[7]) else $error("pins not passed to host");
  chk_pin_enable: assert property (deep_sleep |-> bypass_pin_group_oe == 4'h5)
    else $error("bypass pin enables wrong");
  chk_sleep_follows: assert property (bypass_pin_group_oe != 4'h0 |-> ##[0:1] deep_sleep)
    else $error("no sleep after bypass");
  chk_sleep_stays: assert property (deep_sleep |=> deep_sleep)
    else $error("sleep left without reset");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("no write response");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  cover property ($rose(deep_sleep));
  cover property (s_axi_arvalid && s_axi_arready);
  cover property (!host_tx_o && host_tx_oe);
endmodule // urb_chk

bind urb_uart urb_chk u_chk (.clock, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .host_rx, .host_cts_n, .host_tx_o,
  .host_tx_oe, .host_rts_n_o, .host_rts_n_oe, .bypass_pin_group_i, .bypass_pin_group_o,
  .bypass_pin_group_oe, .deep_sleep);

/* File: verif/urb_host.sv */
// host side model: drives rx and cts, decodes the device serial output
`timescale 1ns/1ps
module urb_host (
  // clock
  input wire clock,
  // serial lines
  input wire host_tx_o,
  output reg host_rx,
  output reg host_cts_n
);
  // rx starts idle high; send and the bench's bypass test drive it after reset
  initial host_rx = 1'b1;
  // active low: clear to send until the bench raises it
  initial host_cts_n = 1'b0;
  // sample mid-bit on the falling edge, away from the device's launch edge
  task recv(input int clks, output reg [7:0] d, output reg p, output reg s);
    int i;
    while (host_tx_o !== 1'b0) @(negedge clock);
    repeat (clks / 2) @(negedge clock);
    for (i = 0; i < 8; i++) begin
      repeat (clks) @(negedge clock);
      d[i] = host_tx_o;
    end
    repeat (clks) @(negedge clock);
    p = host_tx_o;
    repeat (clks) @(negedge clock);
    s = host_tx_o;
  endtask
  // drive one character into the device: start, 8 data lsb first, parity, one stop
  task send(input int clks, input [7:0] d, input reg p);
    reg [10:0] f;
    int i;
    f = {1'b1, p, d, 1'b0};
    @(posedge clock);
    for (i = 0; i < 11; i++) begin
      host_rx <= f[i];
      repeat (clks) @(posedge clock);
    end
  endtask
endmodule // urb_host

/* File: verif/tb_top.sv */
// self-checking bench for the uart rate and bypass block
`timescale 1ns/1ps
`include "urb_consts.vh"
module tb_top;
  reg clock = 1'b0;
  reg nrst;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg [7:0] s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [7:4] bypass_pin_group_i = 4'hf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire host_rx, host_cts_n, host_tx_o, host_tx_oe, host_rts_n_o, host_rts_n_oe, deep_sleep;
  wire [7:4] bypass_pin_group_o, bypass_pin_group_oe;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  reg [31:0] rd_q;
  reg [1:0] resp_q;
  always #2.5 clock = ~clock;
  urb_uart #(.CLK_HZ(200000000)) dut (.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .host_rx, .host_tx_o, .host_tx_oe, .host_cts_n, .host_rts_n_o, .host_rts_n_oe,
    .bypass_pin_group_i, .bypass_pin_group_o, .bypass_pin_group_oe, .deep_sleep);
  urb_host host (.clock, .host_tx_o, .host_rx, .host_cts_n);
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      stop_test();
    end
  end
  task check(input string what, input [31:0] exp, input [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // handshakes are judged at the falling edge, where ready and valid have settled
  task wr(input [7:0] a, input [31:0] d);
    reg ta, tw, done;
    done = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      resp_q = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [7:0] a);
    reg ta, done;
    done = 1'b0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(negedge clock);
      ta = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task rst;
    // reset is launched on a rising edge like every other input
    @(posedge clock);
    nrst <= 1'b0;
    repeat (20) @(posedge clock);
    check("oe in reset", 0, {host_tx_oe, host_rts_n_oe, bypass_pin_group_oe});
    nrst <= 1'b1;
    @(posedge clock);
  endtask
  task t_regs;
    rd(`URB_OFS_BAUD);
    check("baud reset", 32'h01d8, rd_q);
    wr(`URB_OFS_BAUD, 32'h2c3d);
    rd(`URB_OFS_BAUD);
    check("baud", 32'h2c3d, rd_q);
    rd(`URB_OFS_STAT);
    check("mode", 0, rd_q[5:4]);
    check("tx oe", 1, host_tx_oe);
    rd(8'h18);
    check("unmapped rd", `URB_RESP_SLVERR, resp_q);
    wr(8'h18, 32'h0);
    check("unmapped wr", `URB_RESP_SLVERR, resp_q);
    $display("register test done");
  endtask
  task t_frame;
    reg [7:0] d;
    reg p, s;
    int k;
    for (k = 0; k < 2; k++) begin
      wr(`URB_OFS_CTRL, k ? 32'h1 : 32'h7);
      wr(`URB_OFS_TXD, 32'ha5);
      host.recv(72, d, p, s);
      check("data", 8'ha5, d);
      check("parity", k ? 0 : 1, p);
      check("stop", 1, s);
      do rd(`URB_OFS_STAT); while (rd_q[0] !== 1'b0);
    end
    $display("frame test done");
  endtask
  task t_rx;
    reg [7:0] d;
    reg p, s;
    int k;
    wr(`URB_OFS_CTRL, 32'h9);
    check("rts ready", 0, host_rts_n_o);
    for (k = 0; k < 2; k++) begin
      // second character carries a wrong even parity bit
      host.send(72, 8'h3c, k[0]);
      rd(`URB_OFS_STAT);
      check("rx status", k ? 3'b011 : 3'b001, rd_q[3:1]);
      check("rts held", 1, host_rts_n_o);
      rd(`URB_OFS_RXD);
      check("rx data", 8'h3c, rd_q);
      rd(`URB_OFS_STAT);
      check("rx cleared", 0, rd_q[3:1]);
      check("rts again", 0, host_rts_n_o);
    end
    host.host_cts_n <= 1'b1;
    wr(`URB_OFS_TXD, 32'h5a);
    repeat (200) @(posedge clock);
    check("cts stall", 1, host_tx_o);
    host.host_cts_n <= 1'b0;
    host.recv(72, d, p, s);
    check("data after cts", 8'h5a, d);
    check("parity after cts", 0, p);
    check("stop after cts", 1, s);
    do rd(`URB_OFS_STAT); while (rd_q[0] !== 1'b0);
    wr(`URB_OFS_CTRL, 32'h0);
    check("rts no flow", 1, host_rts_n_o);
    $display("receive and flow test done");
  endtask
  task t_bypass;
    int v;
    // the bench opens no radio links, so bypass may be entered at once
    wr(`URB_OFS_CMD, `URB_CMD_BYPASS);
    rd(`URB_OFS_STAT);
    check("sleep", 2'b11, rd_q[5:4]);
    for (v = 0; v < 2; v++) begin
      @(posedge clock);
      host.host_rx <= v[0];
      host.host_cts_n <= ~v[0];
      bypass_pin_group_i <= {v[0], 1'b0, v[0], 1'b0};
      @(negedge clock);
      check("pass", {v[0], ~v[0], v[0], v[0]}, {bypass_pin_group_o[4], bypass_pin_group_o[6], host_tx_o,
        host_rts_n_o});
    end
    rst();
    rd(`URB_OFS_STAT);
    check("mode after reset", 0, {deep_sleep, rd_q[5:4]});
    $display("bypass test done");
  endtask
  task t_rate;
    reg [15:0] tab [0:2];
    int k, e, n;
    tab = '{16'h2c3d, 16'h01d8, 16'h0027};
    for (k = 0; k < 3; k++) begin
      rst();
      wr(`URB_OFS_BAUD, {16'h0, tab[k]});
      e = 819200 / tab[k];
      n = 0;
      fork
        wr(`URB_OFS_TXD, 32'h55);
        begin
          while (host_tx_o !== 1'b0) @(negedge clock);
          while (host_tx_o === 1'b0) begin
            n++;
            @(negedge clock);
          end
        end
      join
      check("bit clocks", e, (n > e - e / 50 - 2 && n < e + e / 50 + 2) ? e : n);
    end
    rst();
    $display("rate test done");
  endtask
  task stop_test;
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    // an update at time zero gives the asynchronous reset a falling edge before the first clock
    nrst <= 1'b0;
    rst();
    t_regs();
    t_frame();
    t_rx();
    t_bypass();
    t_rate();
    stop_test();
  end
endmodule // tb_top
